// [rtl/ppc_blink_div.sv]
// Blink divider: toggles a phase every half blink period.
// Assumes one clock domain; the phase is shared by all ports.
`timescale 1ns/1ps
module ppc_blink_div #(
  parameter int HALF_CYC = ppc_pkg::BLINK_HALF_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  output logic phase
);
  typedef struct packed {
    logic [31:0] cnt;
    logic ph;
  } ppc_div_t;
  ppc_div_t s_r;
  ppc_div_t s_nxt;
  always_comb
  begin
    s_nxt = s_r;
    if (s_r.cnt >= 32'(HALF_CYC - 1))
    begin
      s_nxt.cnt = 32'h0;
      s_nxt.ph = ~s_r.ph;
    end
    else
    begin
      s_nxt.cnt = s_r.cnt + 32'h1;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end
  assign phase = s_r.ph;
endmodule // ppc_blink_div

// [rtl/ppc_pkg.sv]
// Package for the port 2/3 control register bank of the power manager.
// Assumes a single 10 MHz system clock and the register write strobe of the device.
package ppc_pkg;
  // Register address and port addresses of the port control write registers
  localparam logic [2:0] REG_ADDR_CTRL = 3'h2;
  localparam logic [2:0] PORT_ADDR_P2 = 3'h1;
  localparam logic [2:0] PORT_ADDR_P3 = 3'h2;
  // Field positions
  localparam int BIT_FAULT_DIS = 7;
  localparam int BIT_SPARE = 6;
  localparam int BIT_CLASS = 5;
  localparam int BIT_BLINK = 4;
  localparam int BIT_LED_LOW = 3;
  localparam int BIT_LED_HIGH = 2;
  localparam int BIT_MODE_HI = 1;
  localparam int BIT_MODE_LO = 0;
  // Reset value of each control register
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Enable modes
  typedef enum logic [1:0] {
    PPC_MODE_OFF = 2'b00,
    PPC_MODE_DCP = 2'b01,
    PPC_MODE_SAMPLE = 2'b10,
    PPC_MODE_DOWN = 2'b11
  } ppc_mode_t;
  // Classification current limit in mA per code
  localparam logic [7:0] CLASS_MA_00 = 8'ha0;
  localparam logic [7:0] CLASS_MA_01 = 8'h50;
  localparam logic [7:0] CLASS_MA_10 = 8'h28;
  localparam logic [7:0] CLASS_MA_11 = 8'h14;
  // Blink period grows with the clock: ms = 13e-5 * f_hz, so cycles = 13 * f_hz^2 / 1e8
  localparam int CLK_HZ = 10_000_000;
  localparam int BLINK_CLK_PER_MS_X100K = 13;
  localparam longint BLINK_PERIOD_CYC =
    (longint'(CLK_HZ) * CLK_HZ * BLINK_CLK_PER_MS_X100K) / 100_000_000;
  localparam int BLINK_HALF_CYC = int'(BLINK_PERIOD_CYC / 2);
endpackage

// [rtl/ppc_port_ctrl.sv]
// Port 2 and port 3 control write registers with decoded per-port outputs.
// Assumes the serial interface delivers a one-cycle write strobe, register and port address,
// and data, all on clk_sys.
`timescale 1ns/1ps
// Contract
// - Fault-disable bit 7 set suspends the port's overload and window-fault timers.
// - Shared class code: port 3 bit 5 is high, port 2 bit 5 low.
// - Class code 00/01/10/11 selects 160/80/40/20 mA limit.
// - Blink bit set blinks the enabled LED; period 0.00013 times clock hertz ms.
// - Low-side bit set drives the port LED low.
// - High-side bit set drives the port LED to the LED supply rail.
// - Mode 00 turns the port off; 01 starts discovery, classification, power-on.
// - Mode 10 samples powered current; 11 powers down an active port.
// - Port fields are per port; bit 5 is a shared setting.
module ppc_port_ctrl #(
  parameter int HALF_CYC = ppc_pkg::BLINK_HALF_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wr_stb,
  input wire logic [2:0] wr_reg_addr,
  input wire logic [2:0] wr_port_addr,
  input wire logic [7:0] wr_data,
  output logic [1:0] timer_hold,
  output logic [1:0] led_low_on,
  output logic [1:0] led_high_on,
  output logic [3:0] port_mode,
  output logic [1:0] start_dcp,
  output logic [1:0] sample_req,
  output logic [1:0] power_down_req,
  output logic [1:0] port_off,
  output logic class_current_code_high,
  output logic class_current_code_low,
  output logic [7:0] class_limit_ma
);
  typedef struct packed {
    logic [1:0] fault_dis;
    logic [1:0] blink;
    logic [1:0] led_low;
    logic [1:0] led_high;
    logic [3:0] mode;
    logic [1:0] cls;
    logic [7:0] limit;
  } ppc_state_t;
  ppc_state_t s_r;
  ppc_state_t s_nxt;
  logic blink_phase;
  logic [1:0] hit;

  ppc_blink_div #(
    .HALF_CYC(HALF_CYC)
  ) u_div (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .phase(blink_phase)
  );

  assign hit[0] = wr_stb && wr_reg_addr == ppc_pkg::REG_ADDR_CTRL
    && wr_port_addr == ppc_pkg::PORT_ADDR_P2;
  assign hit[1] = wr_stb && wr_reg_addr == ppc_pkg::REG_ADDR_CTRL
    && wr_port_addr == ppc_pkg::PORT_ADDR_P3;

  always_comb
  begin
    s_nxt = s_r;
    for (int p = 0; p < 2; p++)
    begin
      if (hit[p])
      begin
        s_nxt.fault_dis[p] = wr_data[ppc_pkg::BIT_FAULT_DIS];
        s_nxt.blink[p] = wr_data[ppc_pkg::BIT_BLINK];
        s_nxt.led_low[p] = wr_data[ppc_pkg::BIT_LED_LOW];
        s_nxt.led_high[p] = wr_data[ppc_pkg::BIT_LED_HIGH];
        s_nxt.mode[2*p +: 2] = wr_data[ppc_pkg::BIT_MODE_HI:ppc_pkg::BIT_MODE_LO];
        s_nxt.cls[p] = wr_data[ppc_pkg::BIT_CLASS]; // Shared bit
        // Bit 6 is not stored
      end
    end
    unique case (s_nxt.cls)
      2'b00: s_nxt.limit = ppc_pkg::CLASS_MA_00;
      2'b01: s_nxt.limit = ppc_pkg::CLASS_MA_01;
      2'b10: s_nxt.limit = ppc_pkg::CLASS_MA_10;
      2'b11: s_nxt.limit = ppc_pkg::CLASS_MA_11;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r <= '0;
      s_r.limit <= ppc_pkg::CLASS_MA_00;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  always_comb
  begin
    for (int p = 0; p < 2; p++)
    begin
      timer_hold[p] = s_r.fault_dis[p];
      led_low_on[p] = s_r.led_low[p] && (!s_r.blink[p] || blink_phase);
      led_high_on[p] = s_r.led_high[p] && (!s_r.blink[p] || blink_phase);
      port_off[p] = s_r.mode[2*p +: 2] == ppc_pkg::PPC_MODE_OFF;
      start_dcp[p] = s_r.mode[2*p +: 2] == ppc_pkg::PPC_MODE_DCP;
      sample_req[p] = s_r.mode[2*p +: 2] == ppc_pkg::PPC_MODE_SAMPLE;
      power_down_req[p] = s_r.mode[2*p +: 2] == ppc_pkg::PPC_MODE_DOWN;
    end
  end
  assign port_mode = s_r.mode;
  assign class_current_code_high = s_r.cls[1];
  assign class_current_code_low = s_r.cls[0];
  assign class_limit_ma = s_r.limit;
endmodule // ppc_port_ctrl

// [tb/ppc_host.sv]
// Host model writing the port control registers.
// Assumes one clock shared with the block.
`timescale 1ns/1ps
module ppc_host (
  input wire logic clk_sys,
  output logic wr_stb = 1'b0,
  output logic [2:0] wr_reg_addr = 3'h0,
  output logic [2:0] wr_port_addr = 3'h0,
  output logic [7:0] wr_data = 8'h00
);
  task automatic wr(input logic [2:0] p, input logic [7:0] d, input logic [2:0] r = 3'h2);
    @(posedge clk_sys);
    wr_stb <= 1'b1;
    wr_reg_addr <= r;
    wr_port_addr <= p;
    wr_data <= d;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
    wr_data <= ~d;
    @(negedge clk_sys);
  endtask
endmodule // ppc_host

// [tb/ppc_monitor.sv]
// Assertions on the port 2/3 control register outputs.
// Assumes binding to ppc_port_ctrl; index 0 is port 2.
`timescale 1ns/1ps
module ppc_monitor (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wr_stb,
  input wire logic [2:0] wr_reg_addr,
  input wire logic [2:0] wr_port_addr,
  input wire logic [7:0] wr_data,
  input wire logic [1:0] timer_hold,
  input wire logic [1:0] led_low_on,
  input wire logic [1:0] led_high_on,
  input wire logic [3:0] port_mode,
  input wire logic [1:0] sample_req,
  input wire logic [1:0] power_down_req,
  input wire logic class_current_code_high,
  input wire logic class_current_code_low,
  input wire logic [7:0] class_limit_ma
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire logic wa = wr_stb && wr_reg_addr == 3'h2;
  wire logic w2 = wa && wr_port_addr == 3'h1;
  wire logic w3 = wa && wr_port_addr == 3'h2;
  a_fault_hold: assert property (w3 |=> timer_hold[1] == $past(wr_data[7]))
    else $error("fault hold bad");
  a_code_low: assert property (w2 |=> class_current_code_low == $past(wr_data[5]))
    else $error("class code low bad");
  a_code_high: assert property (w3 |=> class_current_code_high == $past(wr_data[5]))
    else $error("class code high bad");
  a_limit_map: assert property (class_limit_ma == (8'ha0 >>
    {class_current_code_high, class_current_code_low})) else $error("class limit bad");
  a_led_low: assert property (w2 && !wr_data[4] |=> led_low_on[0] == $past(wr_data[3]))
    else $error("low side bad");
  a_led_high: assert property (w3 && !wr_data[4] |=> led_high_on[1] == $past(wr_data[2]))
    else $error("high side bad");
  a_mode_take: assert property (w2 |=> port_mode[1:0] == $past(wr_data[1:0]))
    else $error("mode bad");
  a_mode_decode: assert property ({power_down_req[1], sample_req[1]} ==
    {&port_mode[3:2], port_mode[3:2] == 2'h2}) else $error("mode decode bad");
  a_port_apart: assert property (w2 |=> $stable(port_mode[3:2]))
    else $error("port 3 disturbed");
  c_blink: cover property (w2 && wr_data[4]);
  c_port3: cover property (w3);
  c_min_limit: cover property (class_limit_ma == 8'h14);
endmodule // ppc_monitor

// [tb/ppc_port_ctrl_tb.sv]
// Testbench for the port 2/3 control registers.
// Assumes a 10 MHz clock and a blink half period of 4 cycles.
`timescale 1ns/1ps
module ppc_port_ctrl_tb;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  int n;
  wire logic wr_stb, class_current_code_high, class_current_code_low;
  wire logic [2:0] wr_reg_addr, wr_port_addr;
  wire logic [7:0] wr_data, class_limit_ma;
  wire logic [1:0] timer_hold, led_low_on, led_high_on, start_dcp, sample_req, power_down_req;
  wire logic [1:0] port_off;
  wire logic [3:0] port_mode;
  ppc_host host (.clk_sys, .wr_stb, .wr_reg_addr, .wr_port_addr, .wr_data);
  ppc_port_ctrl #(.HALF_CYC(4)) dut (.clk_sys, .rst_n, .wr_stb, .wr_reg_addr, .wr_port_addr,
    .wr_data, .timer_hold, .led_low_on, .led_high_on, .port_mode, .start_dcp, .sample_req,
    .power_down_req, .port_off, .class_current_code_high, .class_current_code_low,
    .class_limit_ma);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("checks=%0d mismatches=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      error_cnt++;
      summarize;
    end
  end
  initial
  begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    chk({port_off, class_limit_ma[7:4]}, 8'h3a);
    $display("test reset done");
    for (int i = 0; i < 4; i++)
    begin
      host.wr(3'h2, {2'h0, i[1], 5'h00});
      host.wr(3'h1, {2'h1, i[0], 5'h00});
      chk(class_limit_ma, 8'ha0 >> i);
      chk({class_current_code_high, class_current_code_low}, 8'(i));
    end
    $display("test class done");
    for (int m = 0; m < 4; m++)
    begin
      host.wr(3'h1, 8'(m));
      host.wr(3'h2, 8'(3 - m));
      chk({power_down_req[0], sample_req[0], start_dcp[0], port_off[0]}, 8'h01 << m);
      chk({power_down_req[1], sample_req[1], start_dcp[1], port_off[1]}, 8'h08 >> m);
      chk(port_mode, 8'(m + 4 * (3 - m)));
    end
    $display("test mode done");
    host.wr(3'h2, 8'hcc);
    host.wr(3'h2, 8'h00, 3'h3);
    chk({timer_hold, led_low_on, led_high_on}, 8'h2a);
    $display("test drive done");
    host.wr(3'h2, 8'h18);
    n = 0;
    repeat (80)
    begin
      @(negedge clk_sys);
      n += led_low_on[1];
    end
    chk(n[7:0], 8'h28);
    chk(ppc_pkg::BLINK_HALF_CYC, 32'h0063_2ea0);
    $display("test blink done");
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    chk({timer_hold, led_low_on, port_off, class_limit_ma}, 32'h0000_03a0);
    $display("test second reset done");
    summarize;
  end
endmodule // ppc_port_ctrl_tb
bind ppc_port_ctrl ppc_monitor mon (.clk_sys, .rst_n, .wr_stb, .wr_reg_addr, .wr_port_addr,
  .wr_data, .timer_hold, .led_low_on, .led_high_on, .port_mode, .sample_req, .power_down_req,
  .class_current_code_high, .class_current_code_low, .class_limit_ma);
